// ### shared/fpr_pkg.sv
// constants, field layouts and types of the flash protection register block
// Notes on behaviour
// - A write to the program-flash protection register that targets a scenario not allowed from the active one is dropped whole.
// - Reading the program-flash protection register always shows the scenario now in force.
// - Allowed moves: 0 to 1,2,3; 1 to 3; 2 to 3; 3 nowhere; 4 to 3; 5 to 2,3,4; 6 to 1,3,4; 7 to any; staying put always allowed.
// - A write to the data-flash size field takes effect only if the new value is larger than the held one.
// - The data-flash enable bit may go from 1 (off) to 0 (on) by software, never back to 1.
// - While the data-flash enable bit is 1 the size field plays no part in protection.
// - On reset the data-flash protection register loads from the byte at 0x7F_FF0D.
// - A double-bit fault on that load clears the enable bit and sets all size bits.
// - Once the load is done, a program or erase aimed at protected data flash is rejected and sets the violation flag.
// - Erasing the whole data-flash block is refused while any data-flash sector is protected.
// - The data-flash register holds the enable in bit 7 and the size in bits 4 to 0, the rest reserved.
// - The protected data-flash area starts at 0x10_0000 and spans 256 bytes times (size code plus one).
// - On reset the program-flash protection register loads from the byte at 0x7F_FF0C.
package fpr_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_PROG_PROT = 8'h00;
   localparam logic [7:0] OFS_DATA_PROT = 8'h04;
   localparam logic [7:0] OFS_FSTATUS   = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h0C;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h10;
   // program-flash protection fields
   localparam int PP_OPEN_BIT  = 7;
   localparam int PP_HDIS_BIT  = 5;
   localparam int PP_HS_LSB    = 3;
   localparam int PP_LDIS_BIT  = 2;
   localparam int PP_LS_LSB    = 0;
   localparam logic [7:0] PP_WR_MASK = 8'hBF;
   // data-flash protection fields
   localparam int DP_EN_BIT    = 7;
   localparam int DP_SIZE_W    = 5;
   localparam logic [7:0] DP_RD_MASK = 8'h9F;
   // values forced by a double-bit fault on load
   localparam logic [7:0] PP_FAULT_VAL = 8'h3F;
   localparam logic [7:0] DP_FAULT_VAL = 8'h1F;
   // reset values held until each byte of the load arrives (fully protected)
   localparam logic [7:0] PP_RST_VAL   = 8'h3F;
   localparam logic [7:0] DP_RST_VAL   = 8'h1F;
   // configuration byte addresses
   localparam logic [22:0] CFG_ADDR_PROG = 23'h7FFF0C;
   localparam logic [22:0] CFG_ADDR_DATA = 23'h7FFF0D;
   // data-flash window
   localparam logic [22:0] DF_BASE      = 23'h100000;
   localparam logic [22:0] DF_END       = 23'h107FFF;
   localparam int          DF_SECT_SH   = 8;
   // status and interrupt bits
   localparam int ST_VIOL_BIT  = 0;
   localparam int ST_FAULT_BIT = 1;
   localparam int ST_W         = 2;
   localparam int ST_DONE_BIT  = 7;
   // command kinds of the flash engine
   typedef enum logic [1:0] {
      FPR_CMD_PROG_DF,
      FPR_CMD_ERASE_SECT_DF,
      FPR_CMD_ERASE_BLK_DF,
      FPR_CMD_OTHER
   } fpr_cmd_t;
   // allowed scenario transitions, row = from, bit = to
   localparam logic [7:0] SCN_ALLOW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                            8'h18, 8'h3C, 8'h5A, 8'hFF};
endpackage

// ### shared/fpr_chk_if.sv
// carrier between the register core and the data-flash checker
interface fpr_chk_if;
   import fpr_pkg::*;
   fpr_cmd_t    kind;     // command kind
   logic [22:0] addr;     // target global address
   logic        dp_en;    // enable bit, 0 means protected
   logic [4:0]  dp_size;  // protected size code
   logic        reject;   // command hits protection
   modport core (output kind, output addr, output dp_en, output dp_size, input reject);
   modport chk  (input kind, input addr, input dp_en, input dp_size, output reject);
endinterface

// ### core/fpr_dchk.sv
// data-flash protection checker, pure combinational
module fpr_dchk (
   fpr_chk_if.chk c   // command and protection state
);
   import fpr_pkg::*;
   logic [22:0] prot_end;
   logic        in_area;
   logic        active;

   // end of protected area, exclusive
   always_comb begin
      prot_end = DF_BASE + (23'({c.dp_size, 1'b0} + 6'h02) << (DF_SECT_SH - 1));
      active   = ~c.dp_en;
      in_area  = (c.addr >= DF_BASE) && (c.addr < prot_end);
   end

   // decide rejection per command kind
   always_comb begin
      unique case (c.kind)
         FPR_CMD_PROG_DF,
         FPR_CMD_ERASE_SECT_DF: c.reject = active && in_area;
         FPR_CMD_ERASE_BLK_DF:  c.reject = active;
         FPR_CMD_OTHER:         c.reject = 1'b0;
      endcase
   end
endmodule

// ### core/fpr_top.sv
// flash protection registers: reset load, write restriction, command check, apb slave
//
// The placing of the registers and the APB slave port were decided locally.
module fpr_top (
   input  wire logic             clk,           // 100 MHz system clock
   input  wire logic             sys_rst,       // synchronous reset, high
   input  wire logic [7:0]       paddr,         // apb address
   input  wire logic             psel,          // apb select
   input  wire logic             penable,       // apb enable
   input  wire logic             pwrite,        // apb direction
   input  wire logic [31:0]      pwdata,        // apb write data
   output logic      [31:0]      prdata,        // apb read data
   output logic                  pready,        // apb ready
   output logic                  pslverr,       // apb error
   output logic                  cfg_req,       // config byte read request
   output logic      [22:0]      cfg_addr,      // config byte address
   input  wire logic             cfg_ack,       // config byte valid
   input  wire logic [7:0]       cfg_data,      // config byte
   input  wire logic             cfg_dbl_err,   // double-bit fault on that phrase
   input  wire logic             cmd_valid,     // command offered, one cycle
   input  wire fpr_pkg::fpr_cmd_t cmd_kind,     // command kind
   input  wire logic [22:0]      cmd_addr,      // command target address
   output logic                  cmd_done,      // verdict pulse
   output logic                  cmd_reject,    // verdict: refused
   output logic                  load_done,     // reset load finished
   output logic                  irq            // level interrupt
);
   import fpr_pkg::*;

   typedef enum logic [1:0] {LD_PROG, LD_DATA, LD_RUN} fpr_ld_t;

   fpr_ld_t        ld_ff,      nxt_ld;
   logic [7:0]     pp_ff,      nxt_pp;
   logic [7:0]     dp_ff,      nxt_dp;
   logic           creq_ff,    nxt_creq;
   logic [22:0]    caddr_ff,   nxt_caddr;
   logic [ST_W-1:0] st_ff,     nxt_st;
   logic [ST_W-1:0] ien_ff,    nxt_ien;
   logic           irq_ff,     nxt_irq;
   logic           rdy_ff,     nxt_rdy;
   logic           err_ff,     nxt_err;
   logic [31:0]    rd_ff,      nxt_rd;
   logic           done_ff,    nxt_done;
   logic           rej_ff,     nxt_rej;
   logic           ldd_ff,     nxt_ldd;

   logic           acc;
   logic           wr_fire;
   logic           mapped;
   logic [2:0]     scn_cur;
   logic [2:0]     scn_new;
   logic [7:0]     pp_cand;
   logic           hit;
   logic [ST_W-1:0] ev_set;
   logic [ST_W-1:0] ev_clr;

   fpr_chk_if chk_bus ();

   fpr_dchk u_dchk (
      .c (chk_bus.chk)
   );

   // feed the checker with the live register contents
   assign chk_bus.kind    = cmd_kind;
   assign chk_bus.addr    = cmd_addr;
   assign chk_bus.dp_en   = dp_ff[DP_EN_BIT];
   assign chk_bus.dp_size = dp_ff[DP_SIZE_W-1:0];

   // apb phase decode; one wait state keeps prdata a flop
   assign acc     = psel && penable;
   assign wr_fire = acc && rdy_ff && pwrite && !err_ff;
   assign mapped  = (paddr == OFS_PROG_PROT) || (paddr == OFS_DATA_PROT) ||
                    (paddr == OFS_FSTATUS) || (paddr == OFS_IRQ_CLR) ||
                    (paddr == OFS_IRQ_EN);

   // scenario of the held value and of the written value
   // the table is indexed from, then to; staying put sits on the diagonal
   assign scn_cur = {pp_ff[PP_OPEN_BIT], pp_ff[PP_HDIS_BIT], pp_ff[PP_LDIS_BIT]};
   assign scn_new = {pwdata[PP_OPEN_BIT], pwdata[PP_HDIS_BIT], pwdata[PP_LDIS_BIT]};

   // size fields may change only while their range is disabled
   always_comb begin
      pp_cand = pwdata[7:0] & PP_WR_MASK;
      if (!pp_ff[PP_HDIS_BIT]) begin
         pp_cand[PP_HS_LSB +: 2] = pp_ff[PP_HS_LSB +: 2];
      end
      if (!pp_ff[PP_LDIS_BIT]) begin
         pp_cand[PP_LS_LSB +: 2] = pp_ff[PP_LS_LSB +: 2];
      end
   end

   // reset load sequencer: program byte first, then data byte
   always_comb begin
      nxt_ld    = ld_ff;
      nxt_creq  = creq_ff;
      nxt_caddr = caddr_ff;
      nxt_ldd   = ldd_ff;
      unique case (ld_ff)
         LD_PROG: begin
            nxt_creq  = 1'b1;
            nxt_caddr = CFG_ADDR_PROG;
            if (creq_ff && cfg_ack) begin
               nxt_ld    = LD_DATA;
               nxt_caddr = CFG_ADDR_DATA;
            end
         end
         // acks may come back to back; cfg_req stays up across both bytes
         LD_DATA: begin
            if (cfg_ack) begin
               nxt_ld   = LD_RUN;
               nxt_creq = 1'b0;
               nxt_ldd  = 1'b1;
            end
         end
         LD_RUN: begin
            nxt_creq = 1'b0;
         end
      endcase
   end

   // protection registers: loaded at reset, restricted afterwards
   always_comb begin
      nxt_pp = pp_ff;
      nxt_dp = dp_ff;
      if (ld_ff == LD_PROG && creq_ff && cfg_ack) begin
         nxt_pp = cfg_dbl_err ? PP_FAULT_VAL : (cfg_data & PP_WR_MASK);
      end
      if (ld_ff == LD_DATA && cfg_ack) begin
         nxt_dp = cfg_dbl_err ? DP_FAULT_VAL : (cfg_data & DP_RD_MASK);
      end
      // a write never meets a load ack: writes are refused until load_done
      if (wr_fire && paddr == OFS_PROG_PROT) begin
         if (SCN_ALLOW[scn_cur][scn_new]) begin
            nxt_pp = pp_cand;
         end
      end
      if (wr_fire && paddr == OFS_DATA_PROT) begin
         nxt_dp[DP_EN_BIT] = dp_ff[DP_EN_BIT] & pwdata[DP_EN_BIT];
         if (pwdata[DP_SIZE_W-1:0] > dp_ff[DP_SIZE_W-1:0]) begin
            nxt_dp[DP_SIZE_W-1:0] = pwdata[DP_SIZE_W-1:0];
         end
      end
   end

   // command verdict; nothing passes before the load is complete
   // a command racing the load is refused by the !ldd_ff term, whatever its kind
   assign hit = chk_bus.reject || !ldd_ff;
   always_comb begin
      nxt_done = cmd_valid;
      nxt_rej  = cmd_valid ? hit : rej_ff;
   end

   // sticky status, set beats clear in the same cycle
   always_comb begin
      ev_set = '0;
      ev_clr = '0;
      ev_set[ST_VIOL_BIT]  = cmd_valid && chk_bus.reject && ldd_ff;
      // the fault bit rises only during the load, never from a later ack
      ev_set[ST_FAULT_BIT] = cfg_ack && cfg_dbl_err && ld_ff != LD_RUN;
      if (wr_fire && paddr == OFS_IRQ_CLR) begin
         ev_clr = pwdata[ST_W-1:0];
      end
      nxt_st  = (st_ff & ~ev_clr) | ev_set;
      nxt_ien = (wr_fire && paddr == OFS_IRQ_EN) ? pwdata[ST_W-1:0] : ien_ff;
      nxt_irq = |(nxt_st & nxt_ien);
   end

   // apb answer: ready one cycle into the access phase
   // read data is latched in the wait state, so prdata never follows paddr
   always_comb begin
      nxt_rdy = acc && !rdy_ff;
      nxt_err = 1'b0;
      nxt_rd  = '0;
      if (acc && !rdy_ff) begin
         // writes before the load ends would race the load, so refuse them
         nxt_err = !mapped || (pwrite && !ldd_ff);
         if (!pwrite) begin
            unique case (paddr)
               OFS_PROG_PROT: nxt_rd = {24'h000000, pp_ff};
               OFS_DATA_PROT: nxt_rd = {24'h000000, dp_ff & DP_RD_MASK};
               OFS_FSTATUS:   nxt_rd = {24'h000000, ldd_ff, 5'h00, st_ff};
               OFS_IRQ_EN:    nxt_rd = {30'h00000000, ien_ff};
               default:       nxt_rd = '0;
            endcase
         end
      end
   end

   // all state registers
   // synchronous reset only; pp_ff, dp_ff and caddr_ff reset to package constants, ld_ff to LD_PROG, the rest to zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ld_ff    <= LD_PROG;
         pp_ff    <= PP_RST_VAL;
         dp_ff    <= DP_RST_VAL;
         creq_ff  <= 1'b0;
         caddr_ff <= CFG_ADDR_PROG;
         st_ff    <= '0;
         ien_ff   <= '0;
         irq_ff   <= 1'b0;
         rdy_ff   <= 1'b0;
         err_ff   <= 1'b0;
         rd_ff    <= '0;
         done_ff  <= 1'b0;
         rej_ff   <= 1'b0;
         ldd_ff   <= 1'b0;
      end else begin
         ld_ff    <= nxt_ld;
         pp_ff    <= nxt_pp;
         dp_ff    <= nxt_dp;
         creq_ff  <= nxt_creq;
         caddr_ff <= nxt_caddr;
         st_ff    <= nxt_st;
         ien_ff   <= nxt_ien;
         irq_ff   <= nxt_irq;
         rdy_ff   <= nxt_rdy;
         err_ff   <= nxt_err;
         rd_ff    <= nxt_rd;
         done_ff  <= nxt_done;
         rej_ff   <= nxt_rej;
         ldd_ff   <= nxt_ldd;
      end
   end

   // outputs straight from flops
   // no logic after these flops, so the ports cannot glitch
   assign prdata     = rd_ff;
   assign pready     = rdy_ff;
   assign pslverr    = err_ff;
   assign cfg_req    = creq_ff;
   assign cfg_addr   = caddr_ff;
   assign cmd_done   = done_ff;
   assign cmd_reject = rej_ff;
   assign load_done  = ldd_ff;
   assign irq        = irq_ff;

   // checks on the guarded behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_prog_bad_drop: assert property (
      wr_fire && paddr == OFS_PROG_PROT && !SCN_ALLOW[scn_cur][scn_new]
      |=> $stable(pp_ff))
      else $error("illegal scenario write changed the register");

   a_scn_three_locked: assert property (
      ldd_ff && scn_cur == 3'd3 |=> scn_cur == 3'd3)
      else $error("scenario 3 was left");

   a_prog_read_live: assert property (
      acc && !rdy_ff && !pwrite && paddr == OFS_PROG_PROT
      |=> prdata[7:0] == $past(pp_ff) && pready)
      else $error("read did not show the active scenario");

   a_dsize_grow_only: assert property (
      ld_ff == LD_RUN |=> dp_ff[DP_SIZE_W-1:0] >= $past(dp_ff[DP_SIZE_W-1:0]))
      else $error("data protection size shrank");

   a_den_one_way: assert property (
      ld_ff == LD_RUN && !dp_ff[DP_EN_BIT] |=> !dp_ff[DP_EN_BIT])
      else $error("data protection enable returned to off");

   a_dfault_full: assert property (
      ld_ff == LD_DATA && cfg_ack && cfg_dbl_err
      |=> dp_ff == DP_FAULT_VAL ##1 st_ff[ST_FAULT_BIT])
      else $error("double fault did not force full data protection");

   a_viol_flag_set: assert property (
      cmd_valid && chk_bus.reject && ldd_ff
      |=> cmd_done && cmd_reject && st_ff[ST_VIOL_BIT])
      else $error("protected command not rejected and flagged");

   a_blk_erase_refuse: assert property (
      cmd_valid && cmd_kind == FPR_CMD_ERASE_BLK_DF && !dp_ff[DP_EN_BIT]
      |=> cmd_reject)
      else $error("block erase allowed under protection");

   a_dsize_ignored: assert property (
      cmd_valid && ldd_ff && dp_ff[DP_EN_BIT] && cmd_kind != FPR_CMD_OTHER
      |=> !cmd_reject)
      else $error("size field used while protection is off");

   a_load_order: assert property (
      ld_ff == LD_PROG && creq_ff && cfg_ack
      |=> cfg_addr == CFG_ADDR_DATA && cfg_req)
      else $error("data byte not fetched after program byte");

   // load sequence: values taken from the two configuration bytes
   a_prog_load_value: assert property (
      ld_ff == LD_PROG && creq_ff && cfg_ack && !cfg_dbl_err
      |=> pp_ff == ($past(cfg_data) & PP_WR_MASK))
      else $error("program protection byte not loaded");

   a_prog_fault_full: assert property (
      ld_ff == LD_PROG && creq_ff && cfg_ack && cfg_dbl_err
      |=> pp_ff == PP_FAULT_VAL)
      else $error("double fault did not force full program protection");

   a_data_load_value: assert property (
      ld_ff == LD_DATA && cfg_ack && !cfg_dbl_err
      |=> dp_ff == ($past(cfg_data) & DP_RD_MASK))
      else $error("data protection byte not loaded");

   a_load_finish: assert property (
      ld_ff == LD_DATA && cfg_ack
      |=> !cfg_req && load_done)
      else $error("load did not finish after the data byte");

   // register invariants once the load is over
   a_dp_rsvd_zero: assert property (
      (dp_ff & ~DP_RD_MASK) == 8'h00)
      else $error("reserved data protection bits set");

   a_scn_legal_move: assert property (
      ldd_ff && $past(ldd_ff) |-> SCN_ALLOW[$past(scn_cur)][scn_cur])
      else $error("scenario moved along a forbidden transition");

   a_hsize_locked: assert property (
      ldd_ff && $past(ldd_ff) && !$past(pp_ff[PP_HDIS_BIT])
      |-> pp_ff[PP_HS_LSB +: 2] == $past(pp_ff[PP_HS_LSB +: 2]))
      else $error("high range size changed while its range was enabled");

   a_lsize_locked: assert property (
      ldd_ff && $past(ldd_ff) && !$past(pp_ff[PP_LDIS_BIT])
      |-> pp_ff[PP_LS_LSB +: 2] == $past(pp_ff[PP_LS_LSB +: 2]))
      else $error("low range size changed while its range was enabled");

   // bus, command and interrupt timing
   a_pready_pulse: assert property (
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   a_done_only_cmd: assert property (
      !cmd_valid |=> !cmd_done)
      else $error("verdict pulse without a command");

   a_viol_cause: assert property (
      $rose(st_ff[ST_VIOL_BIT]) |-> $past(cmd_valid && chk_bus.reject && ldd_ff))
      else $error("violation flag set without a rejected command");

   a_irq_level: assert property (
      irq == |(st_ff & ien_ff))
      else $error("interrupt does not follow enabled status");
endmodule

// ### tb/fpr_top_test.sv
// self-checking bench for the flash protection register block
module fpr_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import fpr_pkg::*;

   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cfg_req;
   logic [22:0] cfg_addr;
   logic        cfg_ack = 1'b0;
   logic [7:0]  cfg_data = 8'h00;
   logic        cfg_dbl_err = 1'b0;
   logic        cmd_valid = 1'b0;
   fpr_cmd_t    cmd_kind = FPR_CMD_OTHER;
   logic [22:0] cmd_addr = 23'h0;
   logic        cmd_done;
   logic        cmd_reject;
   logic        load_done;
   logic        irq;
   int          n_errors = 0;
   int          comparisons = 0;
   // legal target scenarios per source scenario, bit = target
   localparam logic [7:0] LEGAL_TO [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                          8'h18, 8'h3C, 8'h5A, 8'hFF};

   // 100 MHz clock
   always #5 clk = ~clk;

   fpr_top DUT (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_req(cfg_req), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_data(cfg_data),
      .cfg_dbl_err(cfg_dbl_err), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_addr(cmd_addr), .cmd_done(cmd_done), .cmd_reject(cmd_reject),
      .load_done(load_done), .irq(irq));

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask

   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic        e;
      apb(a, 1'b1, {24'h0, d}, rd, e);
   endtask

   task automatic rdv(input logic [7:0] a, output logic [31:0] rd);
      logic e;
      apb(a, 1'b0, 32'h0, rd, e);
   endtask

   // reset, then serve both configuration bytes
   task automatic boot(input logic [7:0] pb, input logic [7:0] db, input logic flt);
      int n;
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cfg_req !== 1'b1 && n < 10);
      if (n >= 10) begin
         n_errors++;
         conclude();
      end
      chk("cfg_addr_prog", 32'h007FFF0C, {9'h0, cfg_addr});
      cfg_ack <= 1'b1;
      cfg_data <= pb;
      cfg_dbl_err <= flt;
      @(posedge clk);
      cfg_ack <= 1'b0;
      cfg_data <= ~pb;
      @(posedge clk);
      chk("cfg_addr_data", 32'h007FFF0D, {9'h0, cfg_addr});
      cfg_ack <= 1'b1;
      cfg_data <= db;
      @(posedge clk);
      cfg_ack <= 1'b0;
      cfg_data <= ~db;
      cfg_dbl_err <= 1'b0;
      @(posedge clk);
      chk("load_done", 32'h1, {31'h0, load_done});
   endtask

   function automatic logic [7:0] exp_pp(logic [7:0] c, logic [7:0] w);
      logic [7:0] ok;
      ok = LEGAL_TO[{c[7], c[5], c[2]}];
      if (ok[{w[7], w[5], w[2]}] !== 1'b1)
         return c;
      return {w[7], 1'b0, w[5], c[5] ? w[4:3] : c[4:3], w[2], c[2] ? w[1:0] : c[1:0]};
   endfunction

   function automatic logic [7:0] exp_dp(logic [7:0] c, logic [7:0] w);
      return {c[7] & w[7], 2'b00, (w[4:0] > c[4:0]) ? w[4:0] : c[4:0]};
   endfunction

   function automatic logic exp_rej(fpr_cmd_t k, logic [22:0] a, logic [7:0] dp);
      if (k == FPR_CMD_OTHER || dp[7])
         return 1'b0;
      if (k == FPR_CMD_ERASE_BLK_DF)
         return 1'b1;
      return a >= 23'h100000 && a < 23'h100000 + (({18'h0, dp[4:0]} + 23'h1) << 8);
   endfunction

   // one command; verdict comes one cycle after it is offered
   task automatic cmd(input fpr_cmd_t k, input logic [22:0] a, input logic [7:0] dp);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_addr <= a;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_addr <= ~a;
      @(posedge clk);
      chk("cmd_done", 32'h1, {31'h0, cmd_done});
      chk("cmd_reject", {31'h0, exp_rej(k, a, dp)}, {31'h0, cmd_reject});
   endtask

   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge clk);
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      conclude();
   end

   initial begin
      logic [31:0] v;
      logic [7:0]  pp;
      logic [7:0]  dp;
      logic [7:0]  w;
      logic        e;
      logic [7:0]  seq [5];
      void'($urandom(77));
      seq = '{8'h82, 8'h85, 8'h05, 8'h86, 8'hFF};
      // loaded values, unmapped access, disabled protection
      boot(8'hFF, 8'h83, 1'b0);
      rdv(OFS_PROG_PROT, v);
      chk("pp_load", 32'hBF, v);
      rdv(OFS_DATA_PROT, v);
      chk("dp_load", 32'h83, v);
      apb(8'h40, 1'b0, 32'h0, v, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      cmd(FPR_CMD_PROG_DF, 23'h100000, 8'h83);
      cmd(FPR_CMD_ERASE_BLK_DF, 23'h100000, 8'h83);
      // size only grows, enable only turns on
      dp = 8'h83;
      for (int i = 0; i < 12; i++) begin
         w = (i < 5) ? seq[i] : 8'($urandom);
         wr(OFS_DATA_PROT, w);
         dp = exp_dp(dp, w);
         rdv(OFS_DATA_PROT, v);
         chk("dp_write", {24'h0, dp}, v);
      end
      // range edges, violation flag and interrupt
      boot(8'hFF, 8'h06, 1'b0);
      wr(OFS_IRQ_EN, 8'h03);
      cmd(FPR_CMD_PROG_DF, 23'h1006FF, 8'h06);
      rdv(OFS_FSTATUS, v);
      chk("status_viol", 32'h81, v);
      irq_chk(1'b1);
      wr(OFS_IRQ_EN, 8'h00);
      irq_chk(1'b0);
      wr(OFS_IRQ_EN, 8'h03);
      irq_chk(1'b1);
      wr(OFS_IRQ_CLR, 8'h01);
      irq_chk(1'b0);
      cmd(FPR_CMD_ERASE_SECT_DF, 23'h100700, 8'h06);
      cmd(FPR_CMD_ERASE_BLK_DF, 23'h107F00, 8'h06);
      cmd(FPR_CMD_OTHER, 23'h100000, 8'h06);
      for (int i = 0; i < 24; i++)
         cmd(fpr_cmd_t'($urandom_range(0, 3)), 23'h0FFF80 + 23'($urandom_range(0, 'h900)), 8'h06);
      // scenario walks from 0xFF first, then from random loaded values
      for (int r = 0; r < 8; r++) begin
         pp = (r == 0) ? 8'hFF : 8'($urandom);
         dp = 8'($urandom);
         boot(pp, dp, 1'b0);
         pp = pp & 8'hBF;
         rdv(OFS_DATA_PROT, v);
         chk("dp_load", {24'h0, dp & 8'h9F}, v);
         rdv(OFS_PROG_PROT, v);
         chk("pp_load", {24'h0, pp}, v);
         for (int i = 0; i < 6; i++) begin
            w = 8'($urandom);
            wr(OFS_PROG_PROT, w);
            pp = exp_pp(pp, w);
            rdv(OFS_PROG_PROT, v);
            chk("pp_write", {24'h0, pp}, v);
         end
      end
      // double fault on load leaves everything protected
      boot(8'($urandom), 8'($urandom), 1'b1);
      rdv(OFS_DATA_PROT, v);
      chk("dp_fault", 32'h1F, v);
      rdv(OFS_PROG_PROT, v);
      chk("pp_fault", 32'h3F, v);
      rdv(OFS_FSTATUS, v);
      chk("status_fault", 32'h82, v);
      cmd(FPR_CMD_PROG_DF, 23'h101FFF, 8'h1F);
      cmd(FPR_CMD_PROG_DF, 23'h102000, 8'h1F);
      conclude();
   end
endmodule
